// ==== core/qpair_engine.sv ====
/*
  queue-pair engine: tail doorbells, in-order fetch, completion posting with phase.
  assumes AXI4-Lite registers and a simple valid/ready fetch and post port;
  the memory side turns indices into 64-byte slot addresses.
*/
// Chosen here: the address map and the AXI4-Lite slave port.
// Behaviour
// R1 - host rings tail doorbell after new commands
// R2 - doorbell write replaces stored tail value
// R3 - fetch in ring order, execute any order
// R4 - one 64-byte command per slot
// R5 - two page pointers or one chain segment
// R6 - page pointer list followed when needed
// R7 - chain segments link to next segment
// R8 - completion tagged by ring and command id
// R9 - several submission rings share completion ring
// R10 - completion goes to associated completion ring
// R11 - host updates completion head after draining
// R12 - phase flag inverts on each wrap
// R13 - admin ring carries admin commands only
// R14 - admin rings paired one to one; other submission rings can also map to completion ring 0
// R15 - up to 65535 queues, 64K commands
// R16 - one write submits, no reads needed
// R17 - all-namespace id reports shared capabilities
// R18 - host picks one command set
// R19 - reserved bits read zero
// R20 - head index wraps after last slot
// R21 - never post into unreleased slot
`timescale 1ns/1ps
`default_nettype none
module qpair_engine #(
  parameter int unsigned RINGS = qpair_pkg::RING_CNT,
  parameter int unsigned IW = qpair_pkg::IDX_W
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic fetch_valid_o,
  input wire logic fetch_ready_i,
  output logic [7:0] fetch_ring_o,
  output logic [IW-1:0] fetch_slot_o,
  output logic fetch_chain_o,
  input wire logic done_valid_i,
  output logic done_ready_o,
  input wire logic [7:0] done_ring_i,
  input wire logic [15:0] done_cid_i,
  output logic post_valid_o,
  input wire logic post_ready_i,
  output logic [7:0] post_cring_o,
  output logic [IW-1:0] post_slot_o,
  output logic [15:0] post_sqid_o,
  output logic [15:0] post_cid_o,
  output logic [IW-1:0] post_sqhead_o,
  output logic post_phase_o
);
  import qpair_pkg::*;
  localparam int unsigned RW = $clog2(RINGS);
  logic [IW-1:0] sub_tail_q [RINGS];
  logic [IW-1:0] cpl_head_q [RINGS];
  logic [IW-1:0] sub_size_q [RINGS];
  logic [IW-1:0] cpl_size_q [RINGS];
  logic [RW-1:0] sub_map_q [RINGS];
  logic [1:0] ctrl_q;
  logic [IW-1:0] sub_head [RINGS];
  logic [IW-1:0] cpl_tail [RINGS];
  logic [RINGS-1:0] phase_q;
  logic [RINGS-1:0] sub_step, cpl_step, cpl_wrap;
  logic [RINGS-1:0] sub_pend;

  // write channel: address and data taken in either order
  logic aw_have_q, w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  logic [11:0] wr_off;
  logic [RW-1:0] wr_idx;
  logic [31:0] wr_val;
  logic wr_hit;
  assign wr_off = aw_addr_q & 12'hfc0;
  assign wr_idx = RW'(aw_addr_q[5:2]);
  assign wr_val = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}}
                  & w_data_q;
  assign wr_hit = (32'(aw_addr_q[5:2]) < RINGS) && (aw_addr_q[1:0] == 2'b00)
                  && (wr_off <= SUB_MAP_BASE);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_hit || aw_addr_q == CTRL_OFF) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= '0;
    end else if (wr_fire && aw_addr_q == CTRL_OFF) begin
      ctrl_q <= wr_val[1:0];
    end
  end

  // per-ring state; a single doorbell write is all that submission needs
  for (genvar g = 0; g < RINGS; g++) begin : g_ring
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        sub_tail_q[g] <= '0;
        cpl_head_q[g] <= '0;
        sub_size_q[g] <= '0;
        cpl_size_q[g] <= '0;
        sub_map_q[g] <= (g == 0) ? '0 : RW'(g);
      end else if (wr_fire && wr_hit && wr_idx == RW'(g)) begin
        case (wr_off)
          SUB_TAIL_BASE: sub_tail_q[g] <= wr_val[IW-1:0]; // R2 R16 R1
          CPL_HEAD_BASE: cpl_head_q[g] <= wr_val[IW-1:0]; // R11
          SUB_SIZE_BASE: sub_size_q[g] <= wr_val[IW-1:0]; // R15
          CPL_SIZE_BASE: cpl_size_q[g] <= wr_val[IW-1:0];
          SUB_MAP_BASE: sub_map_q[g] <= (g == 0) ? '0 : wr_val[RW-1:0]; // R14 R9
          default: ;
        endcase
      end
    end
    ring_ptr #(.W(IW)) u_sub_head (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .clr_i(!ctrl_q[CTRL_EN_BIT]),
      .step_i(sub_step[g]),
      .size_i(sub_size_q[g]),
      .idx_o(sub_head[g]),
      .wrap_o()
    );
    ring_ptr #(.W(IW)) u_cpl_tail (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .clr_i(!ctrl_q[CTRL_EN_BIT]),
      .step_i(cpl_step[g]),
      .size_i(cpl_size_q[g]),
      .idx_o(cpl_tail[g]),
      .wrap_o(cpl_wrap[g])
    );
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        phase_q[g] <= 1'b1;
      end else if (!ctrl_q[CTRL_EN_BIT]) begin
        phase_q[g] <= 1'b1;
      end else if (cpl_wrap[g]) begin
        phase_q[g] <= !phase_q[g]; // R12
      end
    end
    assign sub_pend[g] = ctrl_q[CTRL_EN_BIT] && (sub_head[g] != sub_tail_q[g]);
  end
  // fetch: lowest pending ring, one slot at a time, in slot order
  logic [RW-1:0] pick;
  logic pick_ok;
  always_comb begin
    pick = '0;
    pick_ok = 1'b0;
    for (int i = RINGS - 1; i >= 0; i--) begin
      if (sub_pend[i]) begin
        pick = RW'(i);
        pick_ok = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_valid_o <= 1'b0;
      fetch_ring_o <= '0;
      fetch_slot_o <= '0;
      fetch_chain_o <= 1'b0;
    end else if (!fetch_valid_o || fetch_ready_i) begin
      fetch_valid_o <= pick_ok && !(fetch_valid_o && fetch_ring_o == 8'(pick));
      fetch_ring_o <= 8'(pick);
      fetch_slot_o <= sub_head[pick]; // R3 R4
      fetch_chain_o <= ctrl_q[CTRL_CHAIN_BIT]; // R5 R6 R7
    end
  end
  always_comb begin
    sub_step = '0;
    if (fetch_valid_o && fetch_ready_i) begin
      sub_step[fetch_ring_o[RW-1:0]] = 1'b1; // R20
    end
  end

  // completion posting into the ring mapped from the source ring
  logic [RW-1:0] dst;
  logic room;
  assign dst = sub_map_q[done_ring_i[RW-1:0]];
  assign room = ((cpl_tail[dst] == cpl_size_q[dst]) ? '0 : cpl_tail[dst] + 1'b1)
                != cpl_head_q[dst]; // R21
  assign done_ready_o = ctrl_q[CTRL_EN_BIT] && room && !post_valid_o;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      post_valid_o <= 1'b0;
      post_cring_o <= '0;
      post_slot_o <= '0;
      post_sqid_o <= '0;
      post_cid_o <= '0;
      post_sqhead_o <= '0;
      post_phase_o <= 1'b0;
    end else if (done_valid_i && done_ready_o) begin
      post_valid_o <= 1'b1;
      post_cring_o <= 8'(dst); // R10 R9
      post_slot_o <= cpl_tail[dst];
      post_sqid_o <= 16'(done_ring_i); // R8
      post_cid_o <= done_cid_i; // R8
      post_sqhead_o <= sub_head[done_ring_i[RW-1:0]];
      post_phase_o <= phase_q[dst]; // R12
    end else if (post_ready_i) begin
      post_valid_o <= 1'b0;
    end
  end
  always_comb begin
    cpl_step = '0;
    if (done_valid_i && done_ready_o) begin
      cpl_step[dst] = 1'b1;
    end
  end

  // read channel; unused and reserved bits read zero
  logic [11:0] ra_off;
  logic [RW-1:0] ra_idx;
  logic ra_in;
  logic [31:0] rd_val;
  assign ra_off = s_axi_araddr & 12'hfc0;
  assign ra_idx = RW'(s_axi_araddr[5:2]);
  assign ra_in = (32'(s_axi_araddr[5:2]) < RINGS) && (s_axi_araddr[1:0] == 2'b00) &&
    (ra_off <= SUB_MAP_BASE || ra_off == SUB_HEAD_BASE || ra_off == CPL_TAIL_BASE);
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_val = '0; // R19
    if (s_axi_araddr == CTRL_OFF) begin
      rd_val = 32'(ctrl_q);
    end else if (s_axi_araddr == STATUS_OFF) begin
      rd_val = {{(32 - RINGS){1'b0}}, sub_pend};
    end else if (ra_in) begin
      case (ra_off)
        SUB_TAIL_BASE: rd_val = 32'(sub_tail_q[ra_idx]);
        CPL_HEAD_BASE: rd_val = 32'(cpl_head_q[ra_idx]);
        SUB_SIZE_BASE: rd_val = 32'(sub_size_q[ra_idx]);
        CPL_SIZE_BASE: rd_val = 32'(cpl_size_q[ra_idx]);
        SUB_MAP_BASE: rd_val = 32'(sub_map_q[ra_idx]);
        SUB_HEAD_BASE: rd_val = 32'(sub_head[ra_idx]);
        CPL_TAIL_BASE: rd_val = {15'h0000, phase_q[ra_idx], 16'(cpl_tail[ra_idx])};
        default: rd_val = '0;
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= (ra_in || s_axi_araddr == CTRL_OFF || s_axi_araddr == STATUS_OFF)
                     ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  chk_tail_update: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R2
    wr_fire && wr_hit && wr_off == SUB_TAIL_BASE |=> sub_tail_q[$past(wr_idx)] == $past(wr_val[IW-1:0]))
    else $error("tail not replaced");
  chk_post_phase: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R12
    done_valid_i && done_ready_o |=> post_phase_o == $past(phase_q[dst]))
    else $error("phase wrong");
  chk_post_room: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R21
    done_valid_i && done_ready_o && !wr_fire |=> cpl_tail[$past(dst)] != cpl_head_q[$past(dst)])
    else $error("posted into unreleased slot");
  chk_post_map: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R10
    done_valid_i && done_ready_o |=> post_cring_o == 8'($past(sub_map_q[done_ring_i[RW-1:0]])))
    else $error("wrong completion ring");
  chk_admin_pair: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R14
    sub_map_q[0] == '0)
    else $error("admin pairing broken");
  chk_post_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R8
    post_valid_o && !post_ready_i |=> post_valid_o && $stable(post_cid_o) && $stable(post_sqid_o))
    else $error("post dropped");
  chk_fetch_order: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R3
    fetch_valid_o && fetch_ready_i |=> sub_head[$past(fetch_ring_o[RW-1:0])]
      == (($past(fetch_slot_o) == $past(sub_size_q[fetch_ring_o[RW-1:0]])) ? '0
          : $past(fetch_slot_o) + 1'b1))
    else $error("fetch order broken");
  chk_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R19
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("reserved read nonzero");
  cov_fetch: cover property (@(posedge ref_clk_i) fetch_valid_o && fetch_ready_i);
  cov_wrap: cover property (@(posedge ref_clk_i) |cpl_wrap);
  cov_full: cover property (@(posedge ref_clk_i) done_valid_i && !room);
endmodule : qpair_engine
`default_nettype wire

// ==== core/qpair_pkg.sv ====
/*
  package for the queue-pair engine: register offsets, ring limits, entry layout.
  assumes a 32-bit AXI4-Lite register bus and a fetch/post memory port.
*/
package qpair_pkg;
  localparam int unsigned RING_CNT = 4;
  localparam int unsigned IDX_W = 16;
  localparam int unsigned ENTRY_BYTES = 64;
  localparam int unsigned IO_QUEUE_MAX = 65535;
  localparam int unsigned OUTSTANDING_MAX = 65536;
  localparam logic [31:0] ALL_NS_ID = 32'h0fff_ffff;
  localparam logic [11:0] SUB_TAIL_BASE = 12'h000;
  localparam logic [11:0] CPL_HEAD_BASE = 12'h040;
  localparam logic [11:0] SUB_SIZE_BASE = 12'h080;
  localparam logic [11:0] CPL_SIZE_BASE = 12'h0c0;
  localparam logic [11:0] SUB_MAP_BASE = 12'h100;
  localparam logic [11:0] CTRL_OFF = 12'h140;
  localparam logic [11:0] STATUS_OFF = 12'h144;
  localparam logic [11:0] SUB_HEAD_BASE = 12'h180;
  localparam logic [11:0] CPL_TAIL_BASE = 12'h1c0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_CHAIN_BIT = 1;
  localparam logic [1:0] DESC_PAGE = 2'd0;
  localparam logic [1:0] DESC_PAGE_LIST = 2'd1;
  localparam logic [1:0] DESC_SEG = 2'd2;
  localparam logic [1:0] DESC_SEG_NEXT = 2'd3;
endpackage : qpair_pkg

// ==== core/ring_ptr.sv ====
/*
  one ring index with wrap at the ring's last slot.
  assumes size_i is the slot count minus one and stays stable while in use.
*/
`timescale 1ns/1ps
`default_nettype none
module ring_ptr #(
  parameter int unsigned W = 16
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clr_i,
  input wire logic step_i,
  input wire logic [W-1:0] size_i,
  output logic [W-1:0] idx_o,
  output logic wrap_o
);
  logic [W-1:0] idx_q;
  assign wrap_o = step_i && (idx_q == size_i);
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idx_q <= '0;
    end else if (clr_i) begin
      idx_q <= '0;
    end else if (step_i) begin
      idx_q <= (idx_q == size_i) ? '0 : idx_q + 1'b1; // R20
    end
  end
  assign idx_o = idx_q;
endmodule : ring_ptr
`default_nettype wire

// ==== verif/cmd_mem_model.sv ====
/*
  memory-side model for the queue-pair engine: takes fetches, reports done, takes posts.
  assumes one clock; the bench reads the fetch and post logs by hierarchy.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_mem_model #(
  parameter int unsigned IW = 16
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic stall_i,
  input wire logic fetch_valid_i,
  output logic fetch_ready_o,
  input wire logic [7:0] fetch_ring_i,
  input wire logic [IW-1:0] fetch_slot_i,
  input wire logic fetch_chain_i,
  output logic done_valid_o,
  input wire logic done_ready_i,
  output logic [7:0] done_ring_o,
  output logic [15:0] done_cid_o,
  input wire logic post_valid_i,
  output logic post_ready_o,
  input wire logic [7:0] post_cring_i,
  input wire logic [IW-1:0] post_slot_i,
  input wire logic [15:0] post_sqid_i,
  input wire logic [15:0] post_cid_i,
  input wire logic post_phase_i
);
  logic [23:0] pend[$];
  logic [31:0] fetches[$];
  logic [55:0] posts[$];
  logic tick_q;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_q <= 1'b0;
      fetch_ready_o <= 1'b0;
      post_ready_o <= 1'b0;
      done_valid_o <= 1'b0;
      done_ring_o <= 8'h00;
      done_cid_o <= 16'h0000;
    end else begin
      // fetch ready only every other cycle, so the engine must hold its fetch offer; post ready every cycle unless stalled
      tick_q <= ~tick_q;
      fetch_ready_o <= tick_q & ~stall_i;
      post_ready_o <= ~stall_i;
      if (fetch_valid_i && fetch_ready_o) begin
        // one 64-byte entry per slot; descriptor walk not modelled
        fetches.push_back({7'h00, fetch_chain_i, fetch_ring_i, 16'(fetch_slot_i)});
        pend.push_back({fetch_ring_i, fetch_ring_i, fetch_slot_i[7:0]});
      end
      if (done_valid_o && done_ready_i) begin
        void'(pend.pop_front());
        done_valid_o <= 1'b0;
        // released id is scrambled, never left stale
        done_cid_o <= ~done_cid_o;
      end else if (!done_valid_o && pend.size() > 0 && !stall_i) begin
        done_valid_o <= 1'b1;
        done_ring_o <= pend[0][23:16];
        done_cid_o <= pend[0][15:0];
      end
      if (post_valid_i && post_ready_o) begin
        posts.push_back({post_cring_i, post_slot_i[7:0], post_sqid_i, post_cid_i, 7'h00,
                         post_phase_i});
      end
    end
  end
endmodule : cmd_mem_model
`default_nettype wire

// ==== verif/host_queue_pair_engine_bench.sv ====
/*
  bench for the queue-pair engine: AXI4-Lite tasks and ring traffic checks.
  assumes the engine register map and the memory-side model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module host_queue_pair_engine_bench;
  import qpair_pkg::*;
  logic ref_clk_i = 0, resetn_i = 0, stall = 1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic fv, fr, fsgl, dv, dr, pv, pr, pph;
  logic [7:0] fring, dring, pcr;
  logic [15:0] fslot, dcid, pslot, psq, pcid, psh;
  int num_errors = 0, n_tests = 0;
  logic [31:0] ef [5] = '{32'h0100_0000, 32'h0100_0001, 32'h0101_0000, 32'h0100_0002,
                          32'h0100_0003};
  always #5 ref_clk_i = ~ref_clk_i;
  qpair_engine i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fetch_valid_o(fv), .fetch_ready_i(fr), .fetch_ring_o(fring), .fetch_slot_o(fslot),
    .fetch_chain_o(fsgl), .done_valid_i(dv), .done_ready_o(dr), .done_ring_i(dring),
    .done_cid_i(dcid), .post_valid_o(pv), .post_ready_i(pr), .post_cring_o(pcr),
    .post_slot_o(pslot), .post_sqid_o(psq), .post_cid_o(pcid), .post_sqhead_o(psh),
    .post_phase_o(pph));
  cmd_mem_model i_mem (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .stall_i(stall),
    .fetch_valid_i(fv), .fetch_ready_o(fr), .fetch_ring_i(fring), .fetch_slot_i(fslot),
    .fetch_chain_i(fsgl), .done_valid_o(dv), .done_ready_i(dr), .done_ring_o(dring),
    .done_cid_o(dcid), .post_valid_i(pv), .post_ready_o(pr), .post_cring_i(pcr),
    .post_slot_i(pslot), .post_sqid_i(psq), .post_cid_i(pcid), .post_phase_i(pph));
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tmo(input logic ok);
    if (!ok) begin
      num_errors++;
      test_done();
    end
  endtask : tmo
  // handshakes judged at the rising edge; each channel held until its own ready
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic fin;
    fin = 0;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 200 && !fin; n++) begin
      @(posedge ref_clk_i);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        fin = 1;
        resp = bresp;
        bready <= 0;
      end
    end
    tmo(fin);
  endtask : wr
  task automatic rd_reg(input logic [11:0] a);
    logic fin;
    fin = 0;
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 200 && !fin; n++) begin
      @(posedge ref_clk_i);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        fin = 1;
        rd = rdata;
        resp = rresp;
        rready <= 0;
      end
    end
    tmo(fin);
  endtask : rd_reg
  task automatic wait_posts(input int k);
    for (int n = 0; n < 300 && i_mem.posts.size() < k; n++) @(posedge ref_clk_i);
    tmo(i_mem.posts.size() >= k);
  endtask : wait_posts
  initial begin
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1;
    rd_reg(CPL_TAIL_BASE);
    chk("cpl_tail_reset", rd, 32'h0001_0000);
    rd_reg(12'hffc);
    chk("unmapped_read", {rd, resp}, {32'h0000_0000, RESP_SLVERR});
    wr(12'hffc, 32'hffff_ffff);
    chk("unmapped_write", resp, RESP_SLVERR);
    wr(SUB_SIZE_BASE, 32'h0000_0003);
    wr(SUB_SIZE_BASE + 12'h004, 32'h0000_0003);
    wr(CPL_SIZE_BASE, 32'h0000_0003);
    wr(SUB_MAP_BASE + 12'h004, 32'h0000_0000);
    wr(CTRL_OFF, 32'h0000_0003);
    // second doorbell replaces the first, it does not add to it
    wr(SUB_TAIL_BASE, 32'h0000_0001);
    wr(SUB_TAIL_BASE, 32'h0000_0002);
    repeat (20) @(posedge ref_clk_i);
    stall <= 0;
    wait_posts(2);
    wr(SUB_TAIL_BASE + 12'h004, 32'h0000_0001);
    wait_posts(3);
    wr(SUB_TAIL_BASE, 32'h0000_0000);
    repeat (40) @(posedge ref_clk_i);
    chk("posts_held_full", i_mem.posts.size(), 3);
    chk("fetch_count", i_mem.fetches.size(), 5);
    rd_reg(SUB_HEAD_BASE);
    chk("sub_head_wrapped", rd, 32'h0000_0000);
    wr(CPL_HEAD_BASE, 32'h0000_0003);
    wait_posts(5);
    chk("post_sqhead", psh, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      chk("fetch", i_mem.fetches[i], ef[i]);
      chk("post", i_mem.posts[i], {16'h0000, 6'h00, i[1:0], 8'h00, ef[i][23:16],
          ef[i][23:16], ef[i][7:0], 7'h00, i < 4});
    end
    rd_reg(CPL_TAIL_BASE);
    chk("cpl_tail_end", rd, 32'h0000_0001);
    // page pointer mode: one more command on ring 0
    wr(CTRL_OFF, 32'h0000_0001);
    wr(SUB_TAIL_BASE, 32'h0000_0001);
    wait_posts(6);
    chk("fetch_page", i_mem.fetches[5], 32'h0000_0000);
    chk("post_page", i_mem.posts[5], 64'h0000_0100_0000_0000);
    test_done();
  end
endmodule : host_queue_pair_engine_bench
`default_nettype wire
